//--- inc/vsod_map.svh
// register offsets, reset values and timing counts of the setpoint and on-delay block
// Function
// - host writes an 8-bit setpoint code; device regulates to it
// - target voltage stays within 0.5 V to 5.5 V inclusive
// - each of the 256 setpoint codes selects one target before droop
// - three sub-ranges: 12.5 mV, 25 mV and 50 mV steps
// - code f9 is 5.225 V, fa 5.250 V, fb 5.300 V, ff 5.500 V
// - on-delay, off-delay and slew settings live in three separate registers
// - on-delay runs from turn-on command until the ramp begins
// - on-delay field is whole milliseconds, 00 none, ff 255 ms
// - nonzero droop slope lowers the target as output current rises
// - setpoint and delay writes are accepted at any time
`ifndef VSOD_MAP_SVH
`define VSOD_MAP_SVH

// i2c device address (7 bits)
`define DEV_ADDR 7'h20

// register offsets
`define OFS_SETPOINT 8'h03
`define OFS_ON_DELAY 8'h20
`define OFS_OFF_DELAY 8'h21
`define OFS_RAMP_SLOPE 8'h22
`define OFS_DROOP 8'h23
`define OFS_STATUS 8'h24

// reset values
`define RST_SETPOINT 8'h00
`define RST_ON_DELAY 8'h00
`define RST_OFF_DELAY 6'h00
`define RST_RAMP_SLOPE 7'h08
`define RST_DROOP 8'h00

// voltages in units of 0.1 mV
`define V_MIN 16'h1388
`define V_MAX 16'hd6d8
`define STEP_FINE 16'h007d
`define STEP_MID 16'h00fa
`define STEP_COARSE 16'h01f4
`define BASE_MID 16'h4f1a
`define BASE_COARSE 16'hcf08
`define CODE_MID 8'h79
`define CODE_COARSE 8'hfb

// timing
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)

`endif

//--- inc/vsod_pkg.sv
// types of the setpoint and on-delay block
package vsod_pkg;
  typedef enum logic [2:0] {st_idle, st_addr, st_ptr, st_wdata, st_rdata} i2c_state_e;
  typedef enum logic [1:0] {range_fine, range_mid, range_coarse} vrange_e;
  typedef enum logic [1:0] {dly_off, dly_count, dly_ramp} delay_state_e;
endpackage

//--- inc/cfg_link.sv
// carrier between register file, setpoint decoder and on-delay timer
`timescale 1ns/1ps
interface cfg_link;
  logic [7:0] setpoint_code;
  logic [7:0] droop_slope;
  logic [7:0] load_current;
  logic [15:0] target;
  vsod_pkg::vrange_e range;
  logic [7:0] on_delay;
  logic on_cmd;
  logic ramp_go;
  logic busy;
  modport regs (output setpoint_code, droop_slope, load_current, on_delay, on_cmd,
                input target, range, ramp_go, busy);
  modport dec (input setpoint_code, droop_slope, load_current, output target, range);
  modport dly (input on_delay, on_cmd, output ramp_go, busy);
endinterface

//--- design/setpoint_decoder.sv
// decodes the setpoint code into a target voltage with droop
`timescale 1ns/1ps
`include "vsod_map.svh"
module setpoint_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // configuration and result
  cfg_link.dec cfg
);
  import vsod_pkg::*;

  logic [15:0] code16;
  logic [15:0] base_next;
  logic [15:0] droop_next;
  logic [15:0] target_next;
  vrange_e range_next;

  assign code16 = {8'h00, cfg.setpoint_code};
  assign droop_next = 16'(({8'h00, cfg.droop_slope} * {8'h00, cfg.load_current}) >> 4);

  // piecewise linear decode
  always_comb begin
    if (cfg.setpoint_code < `CODE_MID) begin
      base_next = 16'(`V_MIN + code16 * `STEP_FINE);
      range_next = range_fine;
    end else if (cfg.setpoint_code < `CODE_COARSE) begin
      base_next = 16'(`BASE_MID + (code16 - {8'h00, `CODE_MID}) * `STEP_MID);
      range_next = range_mid;
    end else begin
      base_next = 16'(`BASE_COARSE + (code16 - {8'h00, `CODE_COARSE}) * `STEP_COARSE);
      range_next = range_coarse;
    end
    if (base_next < 16'(`V_MIN + droop_next)) begin
      target_next = `V_MIN;
    end else begin
      target_next = base_next - droop_next;
    end
    if (target_next > `V_MAX) begin
      target_next = `V_MAX;
    end
  end

  // registered target
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg.target <= `V_MIN;
      cfg.range <= range_fine;
    end else begin
      cfg.target <= target_next;
      cfg.range <= range_next;
    end
  end
endmodule

//--- design/on_delay_timer.sv
// counts the turn-on delay in millisecond ticks
`timescale 1ns/1ps
`include "vsod_map.svh"
module on_delay_timer #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // configuration and status
  cfg_link.dly cfg
);
  import vsod_pkg::*;

  delay_state_e state_reg;
  logic [15:0] tick_cnt_reg;
  logic [7:0] ms_cnt_reg;
  logic cmd_prev_reg;
  logic tick;
  logic start;

  assign tick = (tick_cnt_reg == 16'(MS_CYCLES - 1));
  assign start = cfg.on_cmd & ~cmd_prev_reg;

  // command edge memory
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_prev_reg <= 1'b0;
    end else begin
      cmd_prev_reg <= cfg.on_cmd;
    end
  end

  // millisecond divider, restarted with each command
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= 16'h0000;
    end else if (start || state_reg != dly_count || tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  // delay sequence
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= dly_off;
      ms_cnt_reg <= 8'h00;
    end else if (!cfg.on_cmd) begin
      state_reg <= dly_off;
      ms_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        dly_off: begin
          if (start) begin
            ms_cnt_reg <= 8'h00;
            state_reg <= dly_count;
          end
        end
        dly_count: begin
          if (ms_cnt_reg >= cfg.on_delay) begin
            state_reg <= dly_ramp;
          end else if (tick) begin
            ms_cnt_reg <= ms_cnt_reg + 8'h01;
          end
        end
        dly_ramp: begin
          state_reg <= dly_ramp;
        end
        default: begin
          state_reg <= dly_off;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg.ramp_go <= 1'b0;
      cfg.busy <= 1'b0;
    end else begin
      cfg.ramp_go <= cfg.on_cmd && (state_reg == dly_ramp);
      cfg.busy <= cfg.on_cmd && (state_reg == dly_count);
    end
  end
endmodule

//--- design/vsod_top.sv
// i2c register bank with setpoint decoder and turn-on delay
`timescale 1ns/1ps
`include "vsod_map.svh"
module vsod_top #(
  parameter int MS_CYCLES = `MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // i2c pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // converter control
  input wire logic on_cmd,
  input wire logic [7:0] load_current,
  output logic ramp_go,
  output logic on_delay_busy,
  // decoded target
  output logic [15:0] target_voltage,
  output vsod_pkg::vrange_e target_range,
  // other sequencing settings
  output logic [5:0] off_delay_time,
  output logic [6:0] ramp_slope_control
);
  import vsod_pkg::*;

  //--------------------------------------------------
  // declarations
  //--------------------------------------------------
  cfg_link cfg ();

  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_s3_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic sda_s3_reg;
  logic on_s1_reg;
  logic on_s2_reg;

  i2c_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic [7:0] tx_reg;
  logic rw_reg;
  logic ack_reg;

  logic [7:0] output_setpoint_code_reg;
  logic [7:0] on_delay_time_reg;
  logic [5:0] off_delay_time_reg;
  logic [6:0] ramp_slope_control_reg;
  logic [7:0] load_droop_slope_reg;

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic rx_state;
  logic byte_done;
  logic addr_match;
  logic write_now;
  logic [7:0] ptr_next;
  logic [7:0] rd_now;

  //--------------------------------------------------
  // register read decode
  //--------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [7:0] ofs);
    case (ofs)
      `OFS_SETPOINT: reg_read = output_setpoint_code_reg;
      `OFS_ON_DELAY: reg_read = on_delay_time_reg;
      `OFS_OFF_DELAY: reg_read = {2'b00, off_delay_time_reg};
      `OFS_RAMP_SLOPE: reg_read = {1'b0, ramp_slope_control_reg};
      `OFS_DROOP: reg_read = load_droop_slope_reg;
      `OFS_STATUS: reg_read = {6'h00, cfg.busy, cfg.ramp_go};
      default: reg_read = 8'h00;
    endcase
  endfunction

  // read data at the current pointer, msb feeds the first driven bit
  always_comb begin
    rd_now = reg_read(ptr_reg);
  end

  //--------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------
  // two stages, third stage for edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  // turn-on command synchroniser
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      on_s1_reg <= 1'b0;
      on_s2_reg <= 1'b0;
    end else begin
      on_s1_reg <= on_cmd;
      on_s2_reg <= on_s1_reg;
    end
  end

  //--------------------------------------------------
  // bus events
  //--------------------------------------------------
  assign start_cond = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  assign stop_cond = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
  assign scl_rise = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall = ~scl_s2_reg & scl_s3_reg;
  assign rx_state = (state_reg == st_addr) || (state_reg == st_ptr) || (state_reg == st_wdata);
  assign byte_done = (bit_cnt_reg == 4'h8);
  assign addr_match = (shift_reg[7:1] == `DEV_ADDR);
  assign ptr_next = ptr_reg + 8'h01;
  // data byte lands at the pointer
  assign write_now = (state_reg == st_wdata) && scl_fall && byte_done && !ack_reg
                     && !start_cond && !stop_cond;

  //--------------------------------------------------
  // i2c slave sequence
  //--------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= st_idle;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= st_addr;
      bit_cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= st_idle;
      ack_reg <= 1'b0;
    end else begin
      case (state_reg)
        st_idle: begin
          bit_cnt_reg <= 4'h0;
        end
        st_addr, st_ptr, st_wdata: begin
          if (scl_rise && !byte_done) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_done && !ack_reg) begin
            // acknowledge phase begins
            if (state_reg == st_addr && !addr_match) begin
              state_reg <= st_idle;
            end else begin
              ack_reg <= 1'b1;
            end
            if (state_reg == st_addr) begin
              rw_reg <= shift_reg[0];
            end
          end else if (scl_fall && byte_done && ack_reg) begin
            // acknowledge phase ends
            ack_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            case (state_reg)
              st_addr: begin
                if (rw_reg) begin
                  tx_reg <= reg_read(ptr_reg);
                  state_reg <= st_rdata;
                end else begin
                  state_reg <= st_ptr;
                end
              end
              st_ptr: begin
                ptr_reg <= shift_reg;
                state_reg <= st_wdata;
              end
              default: begin
                ptr_reg <= ptr_next;
              end
            endcase
          end
        end
        st_rdata: begin
          if (scl_rise && !byte_done) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_rise && byte_done) begin
            // host acknowledge or end of read
            if (sda_s2_reg) begin
              state_reg <= st_idle;
            end else begin
              bit_cnt_reg <= 4'h0;
              ptr_reg <= ptr_next;
              tx_reg <= reg_read(ptr_next);
            end
          end
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end

  //--------------------------------------------------
  // open-drain data drive
  //--------------------------------------------------
  // set on scl falling edges, released at once on start, stop or idle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (start_cond || stop_cond || state_reg == st_idle) begin
        sda_oe <= 1'b0;
      end else if (scl_fall) begin
        if (rx_state && byte_done && !ack_reg) begin
          sda_oe <= (state_reg != st_addr) || addr_match;
        end else if (rx_state && byte_done && ack_reg) begin
          sda_oe <= (state_reg == st_addr) && rw_reg && !rd_now[7];
        end else if (state_reg == st_rdata && byte_done) begin
          sda_oe <= 1'b0;
        end else if (state_reg == st_rdata) begin
          sda_oe <= !tx_reg[3'h7 - bit_cnt_reg[2:0]];
        end
      end
    end
  end

  //--------------------------------------------------
  // configuration registers
  //--------------------------------------------------
  // writes taken whether on or off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      output_setpoint_code_reg <= `RST_SETPOINT;
      on_delay_time_reg <= `RST_ON_DELAY;
      load_droop_slope_reg <= `RST_DROOP;
    end else if (write_now) begin
      if (ptr_reg == `OFS_SETPOINT) begin
        output_setpoint_code_reg <= shift_reg;
      end
      if (ptr_reg == `OFS_ON_DELAY) begin
        on_delay_time_reg <= shift_reg;
      end
      if (ptr_reg == `OFS_DROOP) begin
        load_droop_slope_reg <= shift_reg;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      off_delay_time_reg <= `RST_OFF_DELAY;
      ramp_slope_control_reg <= `RST_RAMP_SLOPE;
    end else if (write_now) begin
      if (ptr_reg == `OFS_OFF_DELAY) begin
        off_delay_time_reg <= shift_reg[5:0];
      end
      if (ptr_reg == `OFS_RAMP_SLOPE) begin
        ramp_slope_control_reg <= shift_reg[6:0];
      end
    end
  end

  assign off_delay_time = off_delay_time_reg;
  assign ramp_slope_control = ramp_slope_control_reg;

  //--------------------------------------------------
  // links to decoder and timer
  //--------------------------------------------------
  assign cfg.setpoint_code = output_setpoint_code_reg;
  assign cfg.droop_slope = load_droop_slope_reg;
  assign cfg.load_current = load_current;
  assign cfg.on_delay = on_delay_time_reg;
  assign cfg.on_cmd = on_s2_reg;

  // target voltage decode
  setpoint_decoder u_decoder (
    .clock(clock),
    .resetn(resetn),
    .cfg(cfg.dec)
  );

  on_delay_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_delay (
    .clock(clock),
    .resetn(resetn),
    .cfg(cfg.dly)
  );

  assign target_voltage = cfg.target;
  assign target_range = cfg.range;
  assign ramp_go = cfg.ramp_go;
  assign on_delay_busy = cfg.busy;
endmodule

//--- verif/vsod_top_asserts.sv
// port assertions for the setpoint and on-delay block
`timescale 1ns/1ps
module vsod_top_asserts #(
  parameter int MS_CYCLES = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // i2c pins
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // converter control
  input wire logic on_cmd,
  input wire logic [7:0] load_current,
  input wire logic ramp_go,
  input wire logic on_delay_busy,
  // decoded target and settings
  input wire logic [15:0] target_voltage,
  input wire vsod_pkg::vrange_e target_range,
  input wire logic [5:0] off_delay_time,
  input wire logic [6:0] ramp_slope_control
);
  import vsod_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // no droop for three cycles
  sequence s_calm;
    (load_current == 8'h00) [*3];
  endsequence
  // command pin low long enough to pass the synchroniser
  sequence s_cmd_gone;
    (!on_cmd) [*5];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // target span
  property p_span;
    target_voltage >= 16'h1388 && target_voltage <= 16'hd6d8;
  endproperty
  property p_fine;
    s_calm ##0 target_range == range_fine |-> target_voltage <= 16'h4e20 && (target_voltage - 16'h1388) % 16'h007d == 16'h0000;
  endproperty
  property p_mid;
    s_calm ##0 target_range == range_mid |-> target_voltage >= 16'h4f1a && target_voltage <= 16'hcd14
      && (target_voltage - 16'h4f1a) % 16'h00fa == 16'h0000;
  endproperty
  property p_coarse;
    s_calm ##0 target_range == range_coarse |-> target_voltage >= 16'hcf08 && (target_voltage - 16'hcf08) % 16'h01f4 == 16'h0000;
  endproperty
  property p_ramp_rise;
    $rose(ramp_go) |-> $past(on_cmd, 3);
  endproperty
  property p_ramp_fall;
    $fell(ramp_go) |-> !$past(on_cmd, 3);
  endproperty
  property p_ramp_off;
    s_cmd_gone |-> !ramp_go;
  endproperty
  property p_busy_off;
    s_cmd_gone |-> !on_delay_busy;
  endproperty
  a_span: assert property (p_span) else $error("target outside span");
  a_fine: assert property (p_fine) else $error("fine sub-range value wrong");
  a_mid: assert property (p_mid) else $error("mid sub-range value wrong");
  a_coarse: assert property (p_coarse) else $error("coarse sub-range value wrong");
  a_ramp_rise: assert property (p_ramp_rise) else $error("ramp rose without command");
  a_ramp_fall: assert property (p_ramp_fall) else $error("ramp fell with command high");
  a_ramp_off: assert property (p_ramp_off) else $error("ramp high with command low");
  a_busy_off: assert property (p_busy_off) else $error("delay count runs without command");
endmodule

bind vsod_top vsod_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_asserts (.clock(clock), .resetn(resetn), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .on_cmd(on_cmd), .load_current(load_current),
  .ramp_go(ramp_go), .on_delay_busy(on_delay_busy), .target_voltage(target_voltage),
  .target_range(target_range), .off_delay_time(off_delay_time), .ramp_slope_control(ramp_slope_control));

//--- verif/i2c_host_model.sv
// i2c host model driving the register bus of the block
`timescale 1ns/1ps
module i2c_host_model (
  // clock
  input wire logic clock,
  // bus lines
  input wire logic sda_line,
  output logic scl,
  output logic host_oe
);
  // model sends no margining commands, so needs no parallel group set-up
  // idle bus, both lines released high
  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one bit: data moves mid-low, sampled at end of high
  task automatic put_bit(input logic b, output logic got);
    tick(4);
    host_oe <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(8);
    got = sda_line;
    scl <= 1'b0;
  endtask
  // start or repeated start, sda falls while scl high
  task automatic start();
    tick(4);
    host_oe <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    host_oe <= 1'b1;
    tick(8);
    scl <= 1'b0;
  endtask
  // stop, sda rises while scl high
  task automatic stop();
    tick(4);
    host_oe <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    host_oe <= 1'b0;
    tick(8);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], g);
    end
    put_bit(1'b1, g);
    acked = ~g;
  endtask
  // one byte read, host nack ends the read
  task automatic recv_byte(output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      b[i] = g;
    end
    put_bit(1'b1, g);
  endtask
endmodule

//--- verif/test_vout_setpoint_on_delay.sv
// self-checking bench for the setpoint and on-delay block
`timescale 1ns/1ps
`include "vsod_map.svh"
module test_vout_setpoint_on_delay;
  import vsod_pkg::*;
  localparam int MS = 10;
  localparam int LIMIT = 60000;
  logic clock, resetn, scl, sda_out, sda_oe, host_oe, sda_wire, on_cmd, ramp_go, on_delay_busy;
  logic [7:0] load_current, rd;
  logic [15:0] target_voltage;
  vrange_e target_range;
  logic [5:0] off_delay_time;
  logic [6:0] ramp_slope_control;
  int n_mismatch = 0, tests_run = 0, cycles = 0, n;
  logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h78, 8'h79, 8'hf9, 8'hfa, 8'hfb, 8'hff};
  logic [15:0] volts [8] = '{16'h1388, 16'h1405, 16'h4e20, 16'h4f1a, 16'hcc1a, 16'hcd14, 16'hcf08, 16'hd6d8};
  vrange_e ranges [8] = '{range_fine, range_fine, range_fine, range_mid, range_mid, range_mid, range_coarse,
    range_coarse};
  logic [7:0] delays [3] = '{8'h00, 8'h03, 8'hff};
  // open-drain data wire with pull-up; device drives sda_out while enabled
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~host_oe;
  vsod_top #(.MS_CYCLES(MS)) DUT (.clock(clock), .resetn(resetn), .scl(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .on_cmd(on_cmd), .load_current(load_current), .ramp_go(ramp_go),
    .on_delay_busy(on_delay_busy), .target_voltage(target_voltage), .target_range(target_range),
    .off_delay_time(off_delay_time), .ramp_slope_control(ramp_slope_control));
  i2c_host_model host (.clock(clock), .sda_line(sda_wire), .scl(scl), .host_oe(host_oe));
  // 10 mhz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ----------------------------------------
  // compare, bus and report tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  // let k edges pass, then look at settled outputs mid-cycle
  task automatic settle(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] data);
    logic a0, a1, a2;
    host.start();
    host.send_byte({`DEV_ADDR, 1'b0}, a0);
    host.send_byte(ofs, a1);
    host.send_byte(data, a2);
    host.stop();
    check_bit("write ack", 1'b1, a0 & a1 & a2);
  endtask
  task automatic reg_read(input logic [7:0] ofs, output logic [7:0] data);
    logic a0, a1, a2;
    host.start();
    host.send_byte({`DEV_ADDR, 1'b0}, a0);
    host.send_byte(ofs, a1);
    host.start();
    host.send_byte({`DEV_ADDR, 1'b1}, a2);
    host.recv_byte(data);
    host.stop();
    check_bit("read ack", 1'b1, a0 & a1 & a2);
  endtask
  // raise the command and time the ramp release
  task automatic measure(input int ms);
    on_cmd <= 1'b1;
    n = 0;
    while (ramp_go !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    check_bit("ramp delay window", 1'b1, n >= ms * MS && n <= ms * MS + 8);
  endtask
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    on_cmd = 1'b0;
    load_current = 8'h00;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    reg_read(`OFS_SETPOINT, rd);
    check_val("setpoint reset", 16'h0000, {8'h00, rd});
    reg_read(`OFS_ON_DELAY, rd);
    check_val("on delay reset", 16'h0000, {8'h00, rd});
    check_val("target reset", 16'h1388, target_voltage);
    check_val("slew reset", 16'h0008, {9'h000, ramp_slope_control});
    // droop lowers the target, floored at 0.5 v
    reg_write(`OFS_SETPOINT, 8'hff);
    reg_write(`OFS_DROOP, 8'h10);
    load_current <= 8'h20;
    settle(3);
    check_val("droop target", 16'hd6b8, target_voltage);
    reg_write(`OFS_SETPOINT, 8'h00);
    reg_write(`OFS_DROOP, 8'hff);
    load_current <= 8'hff;
    settle(3);
    check_val("droop floor", 16'h1388, target_voltage);
    @(posedge clock);
    load_current <= 8'h00;
    reg_write(`OFS_DROOP, 8'h00);
    // on-delay at zero, 3 ms and full scale
    for (int i = 0; i < 3; i++) begin
      reg_write(`OFS_ON_DELAY, delays[i]);
      measure(delays[i]);
      on_cmd <= 1'b0;
      settle(6);
      check_bit("ramp after off", 1'b0, ramp_go);
    end
    // abort in mid-count, busy seen on pin and in status, then restart from zero
    reg_write(`OFS_ON_DELAY, 8'hff);
    on_cmd <= 1'b1;
    reg_read(`OFS_STATUS, rd);
    check_val("status counting", 16'h0002, {8'h00, rd});
    check_bit("busy counting", 1'b1, on_delay_busy);
    on_cmd <= 1'b0;
    settle(6);
    check_bit("busy after abort", 1'b0, on_delay_busy);
    reg_write(`OFS_ON_DELAY, 8'h05);
    measure(5);
    // decode table while the converter runs
    foreach (codes[i]) begin
      reg_write(`OFS_SETPOINT, codes[i]);
      check_val("target", volts[i], target_voltage);
      check_val("range", {14'h0000, ranges[i]}, {14'h0000, target_range});
      reg_read(`OFS_SETPOINT, rd);
      check_val("setpoint readback", {8'h00, codes[i]}, {8'h00, rd});
    end
    // other settings, reserved bits, status and unmapped reads
    reg_write(`OFS_OFF_DELAY, 8'hff);
    check_val("off delay out", 16'h003f, {10'h000, off_delay_time});
    reg_read(`OFS_OFF_DELAY, rd);
    check_val("off delay read", 16'h003f, {8'h00, rd});
    reg_write(`OFS_RAMP_SLOPE, 8'h55);
    check_val("slew out", 16'h0055, {9'h000, ramp_slope_control});
    reg_write(`OFS_STATUS, 8'hff);
    reg_read(`OFS_STATUS, rd);
    check_val("status", 16'h0001, {8'h00, rd});
    reg_read(8'h40, rd);
    check_val("unmapped read", 16'h0000, {8'h00, rd});
    final_report();
  end
endmodule
